// ---- tmr_cfg.svh ----
// Register offsets, field positions, reset values and counts of the timer
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
`define TMR_OFS_CTRL 4'h0
`define TMR_OFS_COUNT 4'h4
`define TMR_OFS_COMPARE 4'h8
`define TMR_OFS_FLAGS 4'hC
`define TMR_CTRL_MODE_LSB 0
`define TMR_CTRL_ACT_LSB 2
`define TMR_CTRL_DIR_BIT 4
`define TMR_FLAG_OVF_BIT 0
`define TMR_FLAG_CMP_BIT 1
`define TMR_RST_BYTE 8'h00
`define TMR_CNT_MAX 8'hFF
`define TMR_CNT_BOTTOM 8'h00
`define TMR_CNT_BELOW_MAX 8'hFE
`define TMR_CNT_ABOVE_BOTTOM 8'h01
`define TMR_RESP_OKAY 2'h0
`define TMR_RESP_SLVERR 2'h2
`endif

// ---- tmr_pin_load.sv ----
// External load on the compare output pin, with a pull-down
`timescale 1ns/1ps
module tmr_pin_load (
  input wire logic aclk,
  input wire logic compare_output_pin,
  input wire logic compare_output_oe_n,
  output logic line_level,
  output int rise_cnt
);
  // Previous line level for edge detection
  logic prev_level = 1'b0;
  // Released line sinks to the pull-down level
  assign line_level = compare_output_oe_n ? 1'b0
    : compare_output_pin;
  initial rise_cnt = 0;
  // Count rising edges seen on the line
  always @(posedge aclk) begin
    if (line_level && !prev_level) begin
      rise_cnt <= rise_cnt + 1;
    end
    prev_level <= line_level;
  end
endmodule

// ---- tmr_pkg.sv ----
// Types shared by the timer block
package tmr_pkg;
  // Counting sequence selected by wave_mode_sel
  typedef enum logic [1:0] {
    TMR_NORMAL = 2'h0,
    TMR_PHASE_PWM = 2'h1,
    TMR_CLEAR_ON_MATCH = 2'h2,
    TMR_FAST_PWM = 2'h3
  } tmr_mode_t;
  // Action taken on the internal output state at a match
  typedef enum logic [1:0] {
    TMR_ACT_OFF = 2'h0,
    TMR_ACT_TOGGLE = 2'h1,
    TMR_ACT_CLEAR = 2'h2,
    TMR_ACT_SET = 2'h3
  } tmr_act_t;
  // Control fields travelling together
  typedef struct packed {
    logic pin_dir_out;
    tmr_act_t cmp_out_action;
    tmr_mode_t wave_mode_sel;
  } tmr_ctrl_t;
endpackage

// ---- tmr_tb.sv ----
// Self-checking bench for the timer behind its register bus
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic timer_tick = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin, oe_n, line_level;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int rise_cnt;
  int error_cnt = 0;
  int check_count = 0;
  logic [1:0] bq[$]; // Expected write responses
  logic [33:0] rq[$]; // Expected read response and data
  // 50 MHz system clock
  always #10 aclk = ~aclk;
  tmr_top dut_u (.aclk(aclk), .aresetn(aresetn), .timer_tick(timer_tick),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .compare_output_pin(pin),
    .compare_output_oe_n(oe_n));
  tmr_pin_load load_u (.aclk(aclk), .compare_output_pin(pin),
    .compare_output_oe_n(oe_n), .line_level(line_level),
    .rise_cnt(rise_cnt));
  // Compare one value and count the outcome
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Print counts and verdict, then stop
  task tally_and_finish;
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // A wait that ran out ends the run
  task bound(input int n);
    if (n > 60) begin
      error_cnt++;
      $display("FAIL at %0t: wait timed out", $time);
      tally_and_finish();
    end
  endtask
  // One register write; address and data offered together
  task wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    n = 0;
    bq.push_back(er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
      n++;
      bound(n);
    end
    do begin
      @(posedge aclk);
      n++;
      bound(n);
    end while (!bvalid);
  endtask
  // One register read with its expected answer noted
  task rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    rq.push_back({er, 24'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      bound(n);
    end while (!arready);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
      bound(n);
    end while (!rvalid);
  endtask
  // Run n back-to-back timer ticks, then let outputs settle
  task ticks(input int n);
    timer_tick <= 1'b1;
    repeat (n) @(posedge aclk);
    timer_tick <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  // Let the registered pin catch up, then compare the line
  task line_is(input logic v);
    repeat (2) @(posedge aclk);
    check({31'h0, line_level}, {31'h0, v});
  endtask
  // Control byte: direction, action, mode
  function logic [7:0] ctl(input logic [1:0] m, input logic [1:0] a,
    input logic d);
    return {3'h0, d, a, m};
  endfunction
  // Scoreboard: oldest note against each response seen
  always @(posedge aclk) begin
    logic [1:0] eb;
    logic [33:0] er;
    // An answer with no note meets a code the block never gives
    eb = 2'h3;
    er = 34'h3_0000_0000;
    if (bvalid && bready) begin
      if (bq.size() > 0) begin
        eb = bq.pop_front();
      end
      check({30'h0, bresp}, {30'h0, eb});
    end
    if (rvalid && rready) begin
      if (rq.size() > 0) begin
        er = rq.pop_front();
      end
      check({30'h0, rresp}, {30'h0, er[33:32]});
      check(rdata, er[31:0]);
    end
  end
  // Main sequence
  initial begin
    int r, k, r0;
    void'($urandom(59));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset state of registers and pin
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), `TMR_RST_BYTE, `TMR_RESP_OKAY);
    end
    check({31'h0, pin}, 32'h0);
    check({31'h0, oe_n}, 32'h1);
    // Misaligned place is refused
    wr(4'h2, 8'h55, `TMR_RESP_SLVERR);
    rd(4'h2, 8'h00, `TMR_RESP_SLVERR);
    // Normal mode wrap and overflow
    wr(`TMR_OFS_COUNT, `TMR_CNT_BELOW_MAX, `TMR_RESP_OKAY);
    ticks(1);
    rd(`TMR_OFS_COUNT, `TMR_CNT_MAX, `TMR_RESP_OKAY);
    rd(`TMR_OFS_FLAGS, 8'h00, `TMR_RESP_OKAY);
    ticks(1);
    rd(`TMR_OFS_COUNT, `TMR_CNT_BOTTOM, `TMR_RESP_OKAY);
    rd(`TMR_OFS_FLAGS, 8'h01, `TMR_RESP_OKAY);
    wr(`TMR_OFS_FLAGS, 8'h01, `TMR_RESP_OKAY);
    rd(`TMR_OFS_FLAGS, 8'h00, `TMR_RESP_OKAY);
    // Random count writes followed by random runs
    for (int i = 0; i < 4; i++) begin
      r = $urandom_range(8'hF0, 8'h10);
      k = 1 + $urandom % 20;
      wr(`TMR_OFS_COUNT, 8'(r), `TMR_RESP_OKAY);
      ticks(k);
      rd(`TMR_OFS_COUNT, 8'(r + k), `TMR_RESP_OKAY);
    end
    wr(`TMR_OFS_FLAGS, 8'h03, `TMR_RESP_OKAY);
    // Count write hides the match on the next tick only
    wr(`TMR_OFS_COMPARE, 8'h05, `TMR_RESP_OKAY);
    wr(`TMR_OFS_COUNT, 8'h05, `TMR_RESP_OKAY);
    ticks(1);
    rd(`TMR_OFS_FLAGS, 8'h00, `TMR_RESP_OKAY);
    wr(`TMR_OFS_COUNT, 8'h04, `TMR_RESP_OKAY);
    ticks(2);
    rd(`TMR_OFS_FLAGS, 8'h02, `TMR_RESP_OKAY);
    wr(`TMR_OFS_FLAGS, 8'h03, `TMR_RESP_OKAY);
    // Clear-on-match with toggling output
    r0 = rise_cnt;
    wr(`TMR_OFS_CTRL, ctl(2'h2, 2'h1, 1'b1), `TMR_RESP_OKAY);
    wr(`TMR_OFS_COMPARE, 8'h03, `TMR_RESP_OKAY);
    wr(`TMR_OFS_COUNT, 8'h00, `TMR_RESP_OKAY);
    ticks(4);
    rd(`TMR_OFS_COUNT, 8'h00, `TMR_RESP_OKAY);
    rd(`TMR_OFS_FLAGS, 8'h02, `TMR_RESP_OKAY);
    line_is(1'b1);
    ticks(4);
    line_is(1'b0);
    check(32'(rise_cnt - r0), 32'h1);
    // Top below count: runs through the wrap instead
    wr(`TMR_OFS_FLAGS, 8'h03, `TMR_RESP_OKAY);
    wr(`TMR_OFS_COUNT, 8'h10, `TMR_RESP_OKAY);
    ticks(8'hF0);
    rd(`TMR_OFS_COUNT, 8'h00, `TMR_RESP_OKAY);
    rd(`TMR_OFS_FLAGS, 8'h01, `TMR_RESP_OKAY);
    // Fast PWM, non-inverting then inverting
    for (int a = 2; a < 4; a++) begin
      wr(`TMR_OFS_FLAGS, 8'h03, `TMR_RESP_OKAY);
      wr(`TMR_OFS_CTRL, ctl(2'h3, 2'(a), 1'b1), `TMR_RESP_OKAY);
      wr(`TMR_OFS_COMPARE, 8'h80, `TMR_RESP_OKAY);
      rd(`TMR_OFS_COMPARE, 8'h80, `TMR_RESP_OKAY);
      wr(`TMR_OFS_COUNT, 8'hFD, `TMR_RESP_OKAY);
      ticks(3);
      rd(`TMR_OFS_COUNT, 8'h00, `TMR_RESP_OKAY);
      rd(`TMR_OFS_FLAGS, 8'h01, `TMR_RESP_OKAY);
      line_is(a == 2);
      ticks(8'h81);
      line_is(a == 3);
      rd(`TMR_OFS_FLAGS, 8'h03, `TMR_RESP_OKAY);
    end
    // Phase-correct PWM: full up slope, turn at max, then down past the match
    wr(`TMR_OFS_CTRL, ctl(2'h1, 2'h2, 1'b1), `TMR_RESP_OKAY);
    wr(`TMR_OFS_COMPARE, 8'h40, `TMR_RESP_OKAY);
    wr(`TMR_OFS_COUNT, 8'h00, `TMR_RESP_OKAY);
    ticks(255);
    rd(`TMR_OFS_COUNT, `TMR_CNT_MAX, `TMR_RESP_OKAY);
    ticks(1);
    rd(`TMR_OFS_COUNT, `TMR_CNT_BELOW_MAX, `TMR_RESP_OKAY);
    line_is(1'b0);
    wr(`TMR_OFS_FLAGS, 8'h03, `TMR_RESP_OKAY);
    ticks(191);
    line_is(1'b1);
    // Action off parks the pin, state is kept
    wr(`TMR_OFS_CTRL, ctl(2'h1, 2'h0, 1'b1), `TMR_RESP_OKAY);
    line_is(1'b0);
    wr(`TMR_OFS_CTRL, ctl(2'h1, 2'h2, 1'b0), `TMR_RESP_OKAY);
    repeat (2) @(posedge aclk);
    check({31'h0, oe_n}, 32'h1);
    wr(`TMR_OFS_CTRL, ctl(2'h1, 2'h2, 1'b1), `TMR_RESP_OKAY);
    line_is(1'b1);
    ticks(63);
    rd(`TMR_OFS_COUNT, `TMR_CNT_BOTTOM, `TMR_RESP_OKAY);
    rd(`TMR_OFS_FLAGS, 8'h02, `TMR_RESP_OKAY);
    ticks(1);
    rd(`TMR_OFS_FLAGS, 8'h03, `TMR_RESP_OKAY);
    ticks(64);
    line_is(1'b0);
    // Inverting action, up match already passed: top sets the level
    wr(`TMR_OFS_CTRL, ctl(2'h1, 2'h3, 1'b1), `TMR_RESP_OKAY);
    ticks(191);
    line_is(1'b1);
    ticks(191);
    line_is(1'b0);
    tally_and_finish();
  end
endmodule

// ---- tmr_top.sv ----
// Eight-bit timer with four waveform modes behind an AXI4-Lite slave
// How it works
// - Normal mode counts up, wraps FF to 00
// - Normal overflow flag set as count becomes zero
// - Normal mode accepts count writes any time
// - Clear-on-match mode clears count at compare value
// - Clear-on-match compare writes are unbuffered
// - Clear-on-match raises match flag at top
// - Clear-on-match toggle action inverts output per match
// - Clear-on-match overflow set passing max to zero
// - Fast PWM counts bottom to max, then clears
// - Fast PWM: clear/set on match, opposite at bottom
// - Fast PWM overflow flag set at max
// - Fast PWM extremes: spike or constant level
// - Fast PWM toggle action, buffering still active
// - Phase PWM counts up, turns at max for one tick, down
// - Phase PWM: up match clears/sets, down match does the opposite
// - Phase PWM overflow flag set at bottom
// - Phase PWM extremes give constant levels
// - Phase PWM output at max equals up-match result, the opposite when compare is max
// - Missed up match still gets symmetric transition
// - Counting depends only on the waveform mode
// - Pin driven only when direction is output
// - Period follows timer tick rate, 256 or 510, compare plus one in clear-on-match
// - Match sets compare flag; write one clears
// - PWM compare writes buffered, copied at max
// - Count write blocks match in next tick
// - Action zero disconnects pin, no output change
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_top
  import tmr_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic timer_tick,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic compare_output_pin,
  output logic compare_output_oe_n
);

  // The decoder needs at least the four offset bits
  if (ADDR_W < 4) begin : g_addr_check
    $error("ADDR_W must be at least 4");
  end

  // Bus side state
  logic aw_hold_reg; // Write address taken, waiting for data
  logic [ADDR_W-1:0] awaddr_reg; // Held write address
  logic w_hold_reg; // Write data taken, waiting for address
  logic [7:0] wdata_reg; // Low byte of held write data
  logic wstrb_reg; // Lane 0 strobe of held write
  logic bvalid_reg; // Write response pending
  logic [1:0] bresp_reg; // Write response code
  logic rvalid_reg; // Read data pending
  logic [1:0] rresp_reg; // Read response code
  logic [31:0] rdata_reg; // Read data word

  // Timer state
  tmr_ctrl_t ctrl_reg; // Mode, action and pin direction
  logic [7:0] count_reg; // count_value
  logic [7:0] cmp_active_reg; // compare_value used by the comparator
  logic [7:0] cmp_buf_reg; // compare_value as software wrote it
  logic count_up_reg; // Phase PWM direction, high when counting up
  logic block_reg; // Suppresses the match of the next tick
  logic ovf_flag_reg; // overflow_flag
  logic cmp_flag_reg; // compare_match_flag
  logic out_state_reg; // Internal compare_output state
  logic pin_reg; // Registered pin level
  logic oe_n_reg; // Registered pin enable

  // Write and read decode, write strobes
  logic do_wr; // Address and data both held
  logic wr_hit; // Held address has no bits above bit 3
  logic wr_ctrl; // Control register write
  logic wr_count; // Count register write
  logic wr_cmp; // Compare register write
  logic wr_flags; // Flag register write (one clears)
  logic rd_hit; // Read address is mapped
  logic [7:0] rd_byte; // Selected read byte

  // Comparator and counter events
  logic at_max; // Count sits at maximum
  logic at_bottom; // Count sits at bottom
  logic pwm_mode; // Either PWM mode is selected
  logic match_hit; // Unblocked compare match on this tick
  logic ovf_event; // Overflow event on this tick
  logic up_level; // Output after an up-counting match
  logic plain_act; // Action applied at a match only
  logic [7:0] count_next; // Counter value after this tick
  logic count_up_next; // Direction after this tick
  logic out_next; // Output state after this tick

  assign do_wr = aw_hold_reg & w_hold_reg;
  assign wr_hit = (awaddr_reg >> 4) == '0;
  assign wr_ctrl = do_wr & wstrb_reg & wr_hit
    & (awaddr_reg[3:0] == `TMR_OFS_CTRL);
  assign wr_count = do_wr & wstrb_reg & wr_hit
    & (awaddr_reg[3:0] == `TMR_OFS_COUNT);
  assign wr_cmp = do_wr & wstrb_reg & wr_hit
    & (awaddr_reg[3:0] == `TMR_OFS_COMPARE);
  assign wr_flags = do_wr & wstrb_reg & wr_hit
    & (awaddr_reg[3:0] == `TMR_OFS_FLAGS);
  assign rd_hit = ((s_axi_araddr >> 4) == '0)
    & (s_axi_araddr[1:0] == 2'h0);

  // Handshake outputs: one write and one read at a time
  assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign compare_output_pin = pin_reg;
  assign compare_output_oe_n = oe_n_reg;

  // Write channel capture, address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      w_hold_reg <= 1'b0;
      wdata_reg <= `TMR_RST_BYTE;
      wstrb_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb_reg <= s_axi_wstrb[0];
      end else if (do_wr) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  // Write response, error for an unmapped offset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `TMR_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_hit && awaddr_reg[1:0] == 2'h0) ?
        `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read byte selection
  always_comb begin
    case (s_axi_araddr[3:0])
      `TMR_OFS_CTRL: rd_byte = {3'h0, ctrl_reg};
      `TMR_OFS_COUNT: rd_byte = count_reg;
      `TMR_OFS_COMPARE: rd_byte = cmp_buf_reg;
      `TMR_OFS_FLAGS: rd_byte = {6'h00, cmp_flag_reg, ovf_flag_reg};
      default: rd_byte = `TMR_RST_BYTE;
    endcase
  end

  // Read channel, data registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `TMR_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_hit ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
      rdata_reg <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Control register; action changes take effect at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= '0;
    end else if (wr_ctrl) begin
      ctrl_reg <= tmr_ctrl_t'(wdata_reg[4:0]);
    end
  end

  assign at_max = count_reg == `TMR_CNT_MAX;
  assign at_bottom = count_reg == `TMR_CNT_BOTTOM;
  assign pwm_mode = ctrl_reg.wave_mode_sel == TMR_FAST_PWM
    || ctrl_reg.wave_mode_sel == TMR_PHASE_PWM;
  // Comparator, silenced for one tick after a count write
  assign match_hit = timer_tick & ~block_reg
    & (count_reg == cmp_active_reg);
  // Action two gives low after an up match, action three high
  assign up_level = ctrl_reg.cmp_out_action == TMR_ACT_SET;
  // Non-PWM modes and the toggle action act on matches alone
  assign plain_act = !pwm_mode
    || ctrl_reg.cmp_out_action == TMR_ACT_TOGGLE;

  // Counting sequence, chosen by the waveform mode only
  always_comb begin
    count_next = count_reg;
    count_up_next = count_up_reg;
    case (ctrl_reg.wave_mode_sel)
      TMR_NORMAL: begin
        count_next = count_reg + 8'h01;
      end
      TMR_CLEAR_ON_MATCH: begin
        // Missed top runs on through FF and wraps
        if (count_reg == cmp_active_reg) begin
          count_next = `TMR_CNT_BOTTOM;
        end else begin
          count_next = count_reg + 8'h01;
        end
      end
      TMR_FAST_PWM: begin
        if (at_max) begin
          count_next = `TMR_CNT_BOTTOM;
        end else begin
          count_next = count_reg + 8'h01;
        end
      end
      TMR_PHASE_PWM: begin
        // Max and bottom each last one tick: 510 per period
        if (count_up_reg && at_max) begin
          count_up_next = 1'b0;
          count_next = `TMR_CNT_BELOW_MAX;
        end else if (!count_up_reg && at_bottom) begin
          count_up_next = 1'b1;
          count_next = `TMR_CNT_ABOVE_BOTTOM;
        end else if (count_up_reg) begin
          count_next = count_reg + 8'h01;
        end else begin
          count_next = count_reg - 8'h01;
        end
      end
      default: begin
        count_next = count_reg;
      end
    endcase
  end

  // Overflow event per mode
  always_comb begin
    case (ctrl_reg.wave_mode_sel)
      TMR_PHASE_PWM: ovf_event = at_bottom;
      TMR_FAST_PWM: ovf_event = at_max;
      TMR_CLEAR_ON_MATCH: ovf_event = at_max;
      default: ovf_event = at_max;
    endcase
  end

  // Output action on match, bottom and top
  always_comb begin
    out_next = out_state_reg;
    if (ctrl_reg.cmp_out_action == TMR_ACT_OFF) begin
      out_next = out_state_reg;
    end else if (plain_act) begin
      // Toggle also serves fast PWM, with buffering kept
      if (match_hit) begin
        case (ctrl_reg.cmp_out_action)
          TMR_ACT_TOGGLE: out_next = ~out_state_reg;
          TMR_ACT_CLEAR: out_next = 1'b0;
          TMR_ACT_SET: out_next = 1'b1;
          default: out_next = out_state_reg;
        endcase
      end
    end else if (ctrl_reg.wave_mode_sel == TMR_FAST_PWM) begin
      // Match at max ignored, so FF gives a constant level
      if (at_max) begin
        out_next = ~up_level;
      end else if (match_hit) begin
        out_next = up_level;
      end
    end else begin
      // At top the level of an up match is restored, the opposite level when compare is max
      if (count_up_reg && at_max) begin
        out_next = (cmp_buf_reg == `TMR_CNT_MAX) ?
          ~up_level : up_level;
      end else if (match_hit) begin
        // Bottom counts as up so compare zero stays constant
        out_next = (count_up_reg || at_bottom) ?
          up_level : ~up_level;
      end
    end
  end

  // Counter and direction, a software write wins over counting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= `TMR_RST_BYTE;
      count_up_reg <= 1'b1;
    end else if (wr_count) begin
      count_reg <= wdata_reg;
    end else if (timer_tick) begin
      count_reg <= count_next;
      count_up_reg <= count_up_next;
    end
  end

  // Match block: armed by a count write, spent by the next tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_reg <= 1'b0;
    end else if (wr_count) begin
      block_reg <= 1'b1;
    end else if (timer_tick) begin
      block_reg <= 1'b0;
    end
  end

  // Compare value: direct outside PWM, copied at max inside
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_active_reg <= `TMR_RST_BYTE;
      cmp_buf_reg <= `TMR_RST_BYTE;
    end else begin
      if (wr_cmp) begin
        cmp_buf_reg <= wdata_reg;
      end
      if (wr_cmp && !pwm_mode) begin
        cmp_active_reg <= wdata_reg;
      end else if (pwm_mode && timer_tick && at_max) begin
        cmp_active_reg <= cmp_buf_reg;
      end
    end
  end

  // Flags: hardware set wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_flag_reg <= 1'b0;
      cmp_flag_reg <= 1'b0;
    end else begin
      if (timer_tick && ovf_event) begin
        ovf_flag_reg <= 1'b1;
      end else if (wr_flags && wdata_reg[`TMR_FLAG_OVF_BIT]) begin
        ovf_flag_reg <= 1'b0;
      end
      if (match_hit) begin
        cmp_flag_reg <= 1'b1;
      end else if (wr_flags && wdata_reg[`TMR_FLAG_CMP_BIT]) begin
        cmp_flag_reg <= 1'b0;
      end
    end
  end

  // Internal output state, moves on ticks only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_state_reg <= 1'b0;
    end else if (timer_tick) begin
      out_state_reg <= out_next;
    end
  end

  // Pin stage: enable follows direction, level needs an action
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      pin_reg <= (ctrl_reg.cmp_out_action != TMR_ACT_OFF)
        & out_state_reg;
      oe_n_reg <= ~ctrl_reg.pin_dir_out;
    end
  end

  // Checks
  a_normal_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_tick && !wr_count && at_max
    && ctrl_reg.wave_mode_sel == TMR_NORMAL |=> count_reg == 8'h00)
    else $error("normal mode did not wrap");
  a_normal_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_tick && at_max && ctrl_reg.wave_mode_sel == TMR_NORMAL
    |=> ovf_flag_reg)
    else $error("overflow flag missed");
  a_ctc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_tick && !wr_count && count_reg == cmp_active_reg
    && ctrl_reg.wave_mode_sel == TMR_CLEAR_ON_MATCH
    |=> count_reg == 8'h00)
    else $error("clear on match failed");
  a_ctc_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    match_hit && ctrl_reg.wave_mode_sel == TMR_CLEAR_ON_MATCH
    && ctrl_reg.cmp_out_action == TMR_ACT_TOGGLE
    |=> out_state_reg != $past(out_state_reg))
    else $error("toggle missed");
  a_fast_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_tick && !wr_count && at_max
    && ctrl_reg.wave_mode_sel == TMR_FAST_PWM |=> at_bottom)
    else $error("fast pwm did not restart");
  a_fast_bottom: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_tick && at_max && ctrl_reg.wave_mode_sel == TMR_FAST_PWM
    && ctrl_reg.cmp_out_action == TMR_ACT_CLEAR && !wr_ctrl
    |-> ##2 pin_reg)
    else $error("fast pwm not set at bottom");
  a_phase_turn: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_tick && !wr_count && at_max && count_up_reg
    && ctrl_reg.wave_mode_sel == TMR_PHASE_PWM
    |=> count_reg == 8'hFE && !count_up_reg)
    else $error("phase pwm did not turn");
  a_phase_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_tick && at_bottom && ctrl_reg.wave_mode_sel == TMR_PHASE_PWM
    |=> ovf_flag_reg)
    else $error("phase pwm overflow missed");
  a_match_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    match_hit |=> cmp_flag_reg)
    else $error("compare flag missed");
  a_write_block: assert property (@(posedge aclk) disable iff (!aresetn)
    block_reg && timer_tick && !cmp_flag_reg |=> !cmp_flag_reg)
    else $error("blocked match set the flag");
  a_pin_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_reg.pin_dir_out |=> compare_output_oe_n)
    else $error("pin driven while input");

endmodule
